// [logic/cpm_map.svh]
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

// Clock and timing figures in their own units.
`define CPM_CLK_HZ 25000000
`define CPM_INTERNAL_GATE_SUPPLY_DLY_MS 220
`define CPM_QUAL_RETRY_S 2
`define CPM_INT_PULSE_US 256
`define CPM_WDT_BASE_S 40
`define CPM_SAFETY_H 10
`define CPM_BLINK_HALF_MS 500

// Register offsets.
`define CPM_REG_INLIM 4'h0
`define CPM_REG_VLIM 4'h1
`define CPM_REG_CHGCTL 4'h2
`define CPM_REG_FAST_CHARGE_CURRENT 4'h3
`define CPM_REG_WDCTL 4'h4
`define CPM_REG_STATUS 4'h5

// Reset values.
`define CPM_RST_IIN 5'h17
`define CPM_RST_VIN 13'h1194
`define CPM_RST_FAST_CHARGE_CURRENT 6'h22
`define CPM_RST_WD_PERIOD 2'h1

// Input current codes, 100 mA per step above 100 mA.
`define CPM_IIN_500MA 5'h04
`define CPM_IIN_2A4 5'h17
`define CPM_IIN_200MA 5'h01

// Source type codes.
`define CPM_SRC_USB 3'h1
`define CPM_SRC_ADAPTER 3'h3

// Tracking offsets in mV.
`define CPM_TRACK_1 13'h00c8
`define CPM_TRACK_2 13'h00fa
`define CPM_TRACK_3 13'h012c

// Charge phase codes and status pin off code.
`define CPM_PH_OFF 2'h0
`define CPM_PH_PRE 2'h1
`define CPM_PH_FAST 2'h2
`define CPM_PH_DONE 2'h3
`define CPM_STAT_FN_OFF 2'h3

// Synchronised input vector positions.
`define CPM_IN_VAC_PRESENT 0
`define CPM_IN_VAC_ABOVE_SLEEP 1
`define CPM_IN_VAC_BELOW_OV 2
`define CPM_IN_VBUS_ABOVE_MIN 3
`define CPM_IN_SYS_ABOVE_2V2 4
`define CPM_IN_BAT_ABOVE_SYSMIN 5
`define CPM_IN_BAT_ABOVE_LOW 6
`define CPM_IN_LIGHT_LOAD 7
`define CPM_IN_FAST_CHARGE_CURRENT_BELOW_TERM 8
`define CPM_IN_VBAT_ABOVE_RECHG 9
`define CPM_IN_IN_DPM 10
`define CPM_IN_IN_TREG 11
`define CPM_IN_CE_N 12
`define CPM_IN_PSEL 13

`endif

// [logic/cpm_pkg.sv]
`default_nettype none
package cpm_pkg;

  typedef enum logic [2:0] {PU_HIZ, PU_QUAL, PU_RETRY, PU_DET, PU_VLIM, PU_RUN} cpm_pu_e;
  typedef enum logic [1:0] {CH_OFF, CH_ACTIVE, CH_DONE, CH_FAULT} cpm_chg_e;

  typedef struct packed {
    logic [13:0] sync1;
    logic [13:0] sync2;
    cpm_pu_e pu;
    cpm_chg_e chg;
    logic [31:0] pu_cnt;
    logic [33:0] wd_cnt;
    logic [39:0] safety_cnt;
    logic [23:0] blink_cnt;
    logic blink;
    logic [12:0] int_cnt;
    logic [2:0] int_pend;
    logic host_mode;
    logic input_good;
    logic power_good;
    logic safety_fault;
    logic [2:0] src_type;
    logic [4:0] iin_reg;
    logic [1:0] track_sel;
    logic [12:0] vin_reg;
    logic chg_en;
    logic pulse_skip_disable;
    logic rechg_sel;
    logic [1:0] stat_fn;
    logic safety_en;
    logic [5:0] fast_charge_current;
    logic [1:0] wd_period;
    logic bsw_rst_en;
    logic bsw_dly;
    logic bsw_off;
    logic internal_gate_supply_en;
    logic high_impedance_state;
    logic badsrc_en;
    logic conv_en;
    logic batsw_on;
    logic pfm_en;
    logic [4:0] iin_eff;
    logic [12:0] vin_eff;
    logic int_n;
    logic stat_oe_n;
    logic [15:0] rdata;
  } cpm_state_s;

endpackage

`default_nettype wire

// [logic/cpm_ctrl.sv]
// Summary of operation
// R1 - Power-on reset restores defaults, registers reachable
// R2 - Power-up runs supply, qualify, detect, vlimit, converter
// R3 - Gate supply needs input, margin, 220 ms
// R4 - Qualification pass sets input good, interrupts
// R5 - Failed qualification retries every 2 seconds
// R6 - Detection done: interrupt, limit, power good, type
// R7 - Select high 500 mA/001, low 2.4 A/011
// R8 - Default mode tracks pin; host forces detection
// R9 - Voltage limit is max of register, tracked battery
// R10 - Below 2.2 V rail, limit at most 200 mA
// R11 - Battery switch off when charging disabled while the converter runs
// R12 - Pulse skipping at light load unless disabled
// R13 - Timeout flag high in default mode only
// R14 - Start in default mode with defaults
// R15 - Default mode: 10-hour safety limit stops charging
// R16 - Kick enters host mode; period 00 disables
// R17 - Expiry resets registers except the input and voltage limits and the battery switch bits
// R18 - Charge starts only when all enables agree
// R19 - Terminate on low current, high voltage, no regulation
// R20 - Recharge below threshold or on enable toggle
// R21 - Status pin low charging, high idle, blinking fault
// R22 - Phase field 00/01/10/11; done interrupts
// R23 - Each event is one 256 us alert pulse
`timescale 1ns/1ps
`default_nettype none
`include "cpm_map.svh"

module cpm_ctrl
  import cpm_pkg::*;
#(
  parameter int unsigned INTERNAL_GATE_SUPPLY_DLY_CYC = `CPM_INTERNAL_GATE_SUPPLY_DLY_MS * (`CPM_CLK_HZ / 1000),
  parameter int unsigned QUAL_RETRY_CYC = `CPM_QUAL_RETRY_S * `CPM_CLK_HZ,
  parameter int unsigned INT_PULSE_CYC = `CPM_INT_PULSE_US * (`CPM_CLK_HZ / 1000000),
  parameter int unsigned WDT_BASE_CYC = `CPM_WDT_BASE_S * `CPM_CLK_HZ,
  parameter longint unsigned SAFETY_CYC = 64'(`CPM_SAFETY_H) * 64'd3600 * 64'(`CPM_CLK_HZ),
  parameter int unsigned BLINK_HALF_CYC = `CPM_BLINK_HALF_MS * (`CPM_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Analog comparator and pin inputs, asynchronous
  input wire logic vac_present,
  input wire logic vac_above_sleep,
  input wire logic vac_below_ov,
  input wire logic vbus_above_min,
  input wire logic sys_above_2v2,
  input wire logic bat_above_sysmin,
  input wire logic bat_above_low,
  input wire logic light_load,
  input wire logic fast_charge_current_below_term,
  input wire logic vbat_above_rechg,
  input wire logic in_dpm,
  input wire logic in_treg,
  input wire logic ce_n,
  input wire logic psel,
  // Battery voltage from the converter, same clock
  input wire logic [12:0] vbat_mv,
  // Power stage controls
  output logic internal_gate_supply_en,
  output logic high_impedance_state,
  output logic badsrc_en,
  output logic conv_en,
  output logic batsw_on,
  output logic pfm_en,
  output logic rechg_sel,
  output logic [4:0] iin_limit,
  output logic [12:0] vin_limit_mv,
  // Host alert and status pin
  output logic int_n,
  output logic stat_out,
  output logic stat_oe_n
);

  cpm_state_s s_ff;
  cpm_state_s nxt_s;

  logic [13:0] in_raw;
  logic [13:0] in_s;
  logic chg_allowed;
  logic wd_expire;
  logic [33:0] wd_limit;
  logic [12:0] track_mv;
  logic [12:0] vtrack;
  logic [2:0] events;
  logic [4:0] psel_iin;
  logic [2:0] psel_src;
  logic internal_gate_supply_ok;

  assign in_raw = {psel, ce_n, in_treg, in_dpm, vbat_above_rechg, fast_charge_current_below_term, light_load,
                   bat_above_low, bat_above_sysmin, sys_above_2v2, vbus_above_min, vac_below_ov,
                   vac_above_sleep, vac_present};
  assign in_s = s_ff.sync2;

  always_comb begin
    nxt_s = s_ff;
    events = 3'h0;
    nxt_s.sync1 = in_raw;
    nxt_s.sync2 = s_ff.sync1;

    psel_iin = in_s[`CPM_IN_PSEL] ? `CPM_IIN_500MA : `CPM_IIN_2A4; // R7
    psel_src = in_s[`CPM_IN_PSEL] ? `CPM_SRC_USB : `CPM_SRC_ADAPTER; // R7

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        `CPM_REG_INLIM: begin
          nxt_s.iin_reg = reg_wdata[4:0];
          nxt_s.track_sel = reg_wdata[6:5];
        end
        `CPM_REG_VLIM: begin
          nxt_s.vin_reg = reg_wdata[12:0];
        end
        `CPM_REG_CHGCTL: begin
          nxt_s.chg_en = reg_wdata[0];
          nxt_s.pulse_skip_disable = reg_wdata[1];
          nxt_s.rechg_sel = reg_wdata[2];
          nxt_s.stat_fn = reg_wdata[4:3];
          nxt_s.safety_en = reg_wdata[6];
          if (reg_wdata[5]) begin
            nxt_s.iin_reg = psel_iin; // R8
            nxt_s.src_type = psel_src; // R8
          end
        end
        `CPM_REG_FAST_CHARGE_CURRENT: begin
          nxt_s.fast_charge_current = reg_wdata[5:0];
        end
        `CPM_REG_WDCTL: begin
          nxt_s.wd_period = reg_wdata[2:1];
          nxt_s.bsw_rst_en = reg_wdata[3];
          nxt_s.bsw_dly = reg_wdata[4];
          nxt_s.bsw_off = reg_wdata[5];
          if (reg_wdata[0]) begin
            nxt_s.host_mode = 1'b1; // R16
            nxt_s.wd_cnt = 34'h0; // R16
          end
        end
        default: begin
        end
      endcase
    end

    // In default mode the select pin drives the limit all the time.
    if (!s_ff.host_mode) begin
      nxt_s.iin_reg = psel_iin; // R8
    end

    // Host watchdog; period code 00 stops it.
    wd_limit = 34'(WDT_BASE_CYC) << (s_ff.wd_period - 2'h1);
    wd_expire = 1'b0;
    if (s_ff.host_mode && s_ff.wd_period != 2'h0 && !(reg_wr && reg_addr == `CPM_REG_WDCTL && reg_wdata[0])) begin
      nxt_s.wd_cnt = s_ff.wd_cnt + 34'h1; // R16
      if (s_ff.wd_cnt >= wd_limit - 34'h1) begin
        wd_expire = 1'b1;
      end
    end
    if (wd_expire) begin
      nxt_s.host_mode = 1'b0; // R17
      nxt_s.wd_cnt = 34'h0;
      nxt_s.track_sel = 2'h0; // R17
      nxt_s.chg_en = 1'b1; // R17
      nxt_s.pulse_skip_disable = 1'b0; // R17
      nxt_s.rechg_sel = 1'b0; // R17
      nxt_s.stat_fn = 2'h0; // R17
      nxt_s.safety_en = 1'b1; // R17
      nxt_s.fast_charge_current = `CPM_RST_FAST_CHARGE_CURRENT; // R17
      nxt_s.wd_period = `CPM_RST_WD_PERIOD; // R17
    end

    // Power-up sequence from the input source.
    internal_gate_supply_ok = in_s[`CPM_IN_VAC_PRESENT] && in_s[`CPM_IN_VAC_ABOVE_SLEEP]; // R3
    nxt_s.badsrc_en = 1'b0;
    case (s_ff.pu)
      PU_HIZ: begin
        if (internal_gate_supply_ok) begin
          nxt_s.pu_cnt = s_ff.pu_cnt + 32'h1;
          if (s_ff.pu_cnt >= INTERNAL_GATE_SUPPLY_DLY_CYC - 1) begin
            nxt_s.pu_cnt = 32'h0;
            nxt_s.pu = PU_QUAL; // R3
            nxt_s.badsrc_en = 1'b1;
          end
        end else begin
          nxt_s.pu_cnt = 32'h0;
        end
      end
      PU_QUAL: begin
        if (in_s[`CPM_IN_VAC_BELOW_OV] && in_s[`CPM_IN_VBUS_ABOVE_MIN]) begin
          nxt_s.input_good = 1'b1; // R4
          events[0] = 1'b1; // R4
          nxt_s.pu = PU_DET; // R2
        end else begin
          nxt_s.pu = PU_RETRY; // R5
        end
      end
      PU_RETRY: begin
        nxt_s.pu_cnt = s_ff.pu_cnt + 32'h1;
        if (s_ff.pu_cnt >= QUAL_RETRY_CYC - 1) begin
          nxt_s.pu_cnt = 32'h0;
          nxt_s.pu = PU_QUAL; // R5
          nxt_s.badsrc_en = 1'b1;
        end
      end
      PU_DET: begin
        nxt_s.iin_reg = psel_iin; // R6
        nxt_s.src_type = psel_src; // R6
        nxt_s.power_good = 1'b1; // R6
        events[1] = 1'b1; // R6
        nxt_s.pu = PU_VLIM; // R2
      end
      PU_VLIM: begin
        nxt_s.pu = PU_RUN; // R2
      end
      PU_RUN: begin
      end
      default: begin
        nxt_s.pu = PU_HIZ;
      end
    endcase
    if (!internal_gate_supply_ok) begin
      nxt_s.pu = PU_HIZ; // R3
      nxt_s.input_good = 1'b0;
      nxt_s.power_good = 1'b0;
      nxt_s.src_type = 3'h0;
      nxt_s.badsrc_en = 1'b0;
      if (s_ff.pu != PU_HIZ) begin
        nxt_s.pu_cnt = 32'h0;
      end
    end
    nxt_s.internal_gate_supply_en = (nxt_s.pu != PU_HIZ); // R3
    nxt_s.high_impedance_state = (nxt_s.pu == PU_HIZ); // R3
    nxt_s.conv_en = (nxt_s.pu == PU_RUN); // R2

    // Charge cycle control.
    chg_allowed = (s_ff.pu == PU_RUN) && s_ff.chg_en && (s_ff.fast_charge_current != 6'h0)
                  && !in_s[`CPM_IN_CE_N] && !s_ff.bsw_off; // R18
    case (s_ff.chg)
      CH_OFF: begin
        nxt_s.safety_cnt = 40'h0;
        nxt_s.safety_fault = 1'b0; // R20
        if (chg_allowed) begin
          nxt_s.chg = CH_ACTIVE; // R18
        end
      end
      CH_ACTIVE: begin
        if (s_ff.safety_en) begin
          nxt_s.safety_cnt = s_ff.safety_cnt + 40'h1;
        end
        if (!chg_allowed) begin
          nxt_s.chg = CH_OFF;
        end else if (s_ff.safety_en && s_ff.safety_cnt >= 40'(SAFETY_CYC - 64'd1)) begin
          nxt_s.safety_fault = 1'b1; // R15
          nxt_s.chg = CH_FAULT; // R15
        end else if (in_s[`CPM_IN_FAST_CHARGE_CURRENT_BELOW_TERM] && in_s[`CPM_IN_VBAT_ABOVE_RECHG]
                     && !in_s[`CPM_IN_IN_DPM] && !in_s[`CPM_IN_IN_TREG]) begin
          nxt_s.chg = CH_DONE; // R19
          events[2] = 1'b1; // R22
        end
      end
      CH_DONE: begin
        if (!chg_allowed) begin
          nxt_s.chg = CH_OFF; // R20
        end else if (!in_s[`CPM_IN_VBAT_ABOVE_RECHG]) begin
          nxt_s.safety_cnt = 40'h0;
          nxt_s.chg = CH_ACTIVE; // R20
        end
      end
      CH_FAULT: begin
        if (!chg_allowed) begin
          nxt_s.chg = CH_OFF; // R20
        end
      end
      default: begin
        nxt_s.chg = CH_OFF;
      end
    endcase

    // Power stage steering.
    nxt_s.batsw_on = !((nxt_s.pu == PU_RUN) && (!s_ff.chg_en || in_s[`CPM_IN_CE_N])) && !s_ff.bsw_off; // R11
    nxt_s.pfm_en = (nxt_s.pu == PU_RUN) && !s_ff.pulse_skip_disable
                   && (in_s[`CPM_IN_LIGHT_LOAD] || !in_s[`CPM_IN_BAT_ABOVE_SYSMIN] || !chg_allowed); // R12
    if (!in_s[`CPM_IN_SYS_ABOVE_2V2] && s_ff.iin_reg > `CPM_IIN_200MA) begin
      nxt_s.iin_eff = `CPM_IIN_200MA; // R10
    end else begin
      nxt_s.iin_eff = s_ff.iin_reg; // R10
    end
    case (s_ff.track_sel)
      2'h1: track_mv = `CPM_TRACK_1;
      2'h2: track_mv = `CPM_TRACK_2;
      2'h3: track_mv = `CPM_TRACK_3;
      default: track_mv = 13'h0;
    endcase
    vtrack = vbat_mv + track_mv;
    if (s_ff.track_sel != 2'h0 && vtrack > s_ff.vin_reg) begin
      nxt_s.vin_eff = vtrack; // R9
    end else begin
      nxt_s.vin_eff = s_ff.vin_reg; // R9
    end

    // Status pin, released when idle, done or switched off.
    nxt_s.blink_cnt = s_ff.blink_cnt + 24'h1;
    if (s_ff.blink_cnt >= 24'(BLINK_HALF_CYC - 1)) begin
      nxt_s.blink_cnt = 24'h0;
      nxt_s.blink = !s_ff.blink;
    end
    if (s_ff.stat_fn == `CPM_STAT_FN_OFF) begin
      nxt_s.stat_oe_n = 1'b1; // R21
    end else if (nxt_s.chg == CH_ACTIVE) begin
      nxt_s.stat_oe_n = 1'b0; // R21
    end else if (nxt_s.chg == CH_FAULT) begin
      nxt_s.stat_oe_n = nxt_s.blink; // R21
    end else begin
      nxt_s.stat_oe_n = 1'b1; // R21
    end

    // Alert pulses; events that arrive during a pulse wait their turn.
    nxt_s.int_pend = s_ff.int_pend + {2'h0, events[0]} + {2'h0, events[1]} + {2'h0, events[2]};
    if (!s_ff.int_n) begin
      nxt_s.int_cnt = s_ff.int_cnt + 13'h1;
      if (s_ff.int_cnt >= 13'(INT_PULSE_CYC - 1)) begin
        nxt_s.int_n = 1'b1; // R23
        nxt_s.int_cnt = 13'h0;
      end
    end else if (s_ff.int_pend != 3'h0) begin
      nxt_s.int_n = 1'b0; // R23
      nxt_s.int_pend = s_ff.int_pend - 3'h1 + {2'h0, events[0]} + {2'h0, events[1]} + {2'h0, events[2]};
    end

    // Read data appear in the cycle after the strobe only.
    nxt_s.rdata = 16'h0;
    if (reg_rd) begin
      case (reg_addr)
        `CPM_REG_INLIM: nxt_s.rdata = {9'h0, s_ff.track_sel, s_ff.iin_reg};
        `CPM_REG_VLIM: nxt_s.rdata = {3'h0, s_ff.vin_reg};
        `CPM_REG_CHGCTL: nxt_s.rdata = {9'h0, s_ff.safety_en, 1'b0, s_ff.stat_fn, s_ff.rechg_sel,
                                        s_ff.pulse_skip_disable, s_ff.chg_en};
        `CPM_REG_FAST_CHARGE_CURRENT: nxt_s.rdata = {10'h0, s_ff.fast_charge_current};
        `CPM_REG_WDCTL: nxt_s.rdata = {10'h0, s_ff.bsw_off, s_ff.bsw_dly, s_ff.bsw_rst_en,
                                       s_ff.wd_period, 1'b0};
        `CPM_REG_STATUS: begin
          nxt_s.rdata[0] = s_ff.input_good;
          nxt_s.rdata[1] = s_ff.power_good;
          nxt_s.rdata[4:2] = s_ff.src_type;
          case (s_ff.chg)
            CH_ACTIVE: nxt_s.rdata[6:5] = in_s[`CPM_IN_BAT_ABOVE_LOW] ? `CPM_PH_FAST : `CPM_PH_PRE; // R22
            CH_DONE: nxt_s.rdata[6:5] = `CPM_PH_DONE; // R22
            default: nxt_s.rdata[6:5] = `CPM_PH_OFF; // R22
          endcase
          nxt_s.rdata[7] = !s_ff.host_mode; // R13
          nxt_s.rdata[8] = s_ff.safety_fault;
          nxt_s.rdata[9] = s_ff.high_impedance_state;
        end
        default: nxt_s.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0; // R1 R14
      s_ff.pu <= PU_HIZ;
      s_ff.chg <= CH_OFF;
      s_ff.iin_reg <= `CPM_RST_IIN;
      s_ff.vin_reg <= `CPM_RST_VIN;
      s_ff.chg_en <= 1'b1;
      s_ff.safety_en <= 1'b1;
      s_ff.fast_charge_current <= `CPM_RST_FAST_CHARGE_CURRENT;
      s_ff.wd_period <= `CPM_RST_WD_PERIOD;
      s_ff.bsw_rst_en <= 1'b1;
      s_ff.high_impedance_state <= 1'b1;
      s_ff.batsw_on <= 1'b1;
      s_ff.iin_eff <= `CPM_IIN_200MA;
      s_ff.vin_eff <= `CPM_RST_VIN;
      s_ff.int_n <= 1'b1;
      s_ff.stat_oe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata = s_ff.rdata;
  assign internal_gate_supply_en = s_ff.internal_gate_supply_en;
  assign high_impedance_state = s_ff.high_impedance_state;
  assign badsrc_en = s_ff.badsrc_en;
  assign conv_en = s_ff.conv_en;
  assign batsw_on = s_ff.batsw_on;
  assign pfm_en = s_ff.pfm_en;
  assign rechg_sel = s_ff.rechg_sel;
  assign iin_limit = s_ff.iin_eff;
  assign vin_limit_mv = s_ff.vin_eff;
  assign int_n = s_ff.int_n;
  assign stat_oe_n = s_ff.stat_oe_n;
  assign stat_out = 1'b0;

endmodule

`default_nettype wire

// [logic/cpm_ctrl_unused_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [test/cpm_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module cpm_ctrl_properties
  import cpm_pkg::*;
#(
  parameter int unsigned INT_PULSE_CYC = 6400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Comparators
  input wire logic vac_present,
  input wire logic sys_above_2v2,
  // Controller outputs
  input wire logic internal_gate_supply_en,
  input wire logic high_impedance_state,
  input wire logic badsrc_en,
  input wire logic conv_en,
  input wire logic batsw_on,
  input wire logic pfm_en,
  input wire logic [4:0] iin_limit,
  input wire logic [12:0] vin_limit_mv,
  input wire logic int_n,
  input wire logic stat_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Counts how long the alert has been held low.
  logic [15:0] low_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 16'h0;
    end else begin
      low_cnt <= int_n ? 16'h0 : low_cnt + 16'h1;
    end
  end

  sequence s_chg_off;
    reg_wr && reg_addr == 4'h2 && !reg_wdata[0];
  endsequence
  sequence s_pfm_off;
    reg_wr && reg_addr == 4'h2 && reg_wdata[1];
  endsequence
  sequence s_stat_off;
    reg_wr && reg_addr == 4'h2 && reg_wdata[4:3] == 2'h3;
  endsequence
  sequence s_vlim_wr;
    reg_wr && reg_addr == 4'h1;
  endsequence
  sequence s_rail_low;
    !sys_above_2v2 [*5];
  endsequence

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0) else $error("read data not idle");
  AST_CONV_ORDER: assert property (conv_en |-> internal_gate_supply_en && !high_impedance_state) else $error("converter before supply");
  AST_QUAL_PULSE: assert property (badsrc_en |-> internal_gate_supply_en ##1 !badsrc_en) else $error("bad qualify pulse");
  AST_HIZ_DROP: assert property (!vac_present |-> ##[1:4] (high_impedance_state && !internal_gate_supply_en)) else $error("no hiz on drop");
  AST_ALERT_WIDTH: assert property ($rose(int_n) |-> low_cnt == 16'(INT_PULSE_CYC)) else $error("alert width");
  AST_RAIL_LIMIT: assert property (s_rail_low |-> iin_limit <= 5'h01) else $error("rail limit too high");
  AST_VLIM_FLOOR: assert property (s_vlim_wr ##3 1'b1 |-> vin_limit_mv >= $past(reg_wdata[12:0], 3))
    else $error("voltage limit below register");
  AST_BATSW_OFF: assert property (s_chg_off ##3 conv_en |-> !batsw_on) else $error("switch on while off");
  AST_PFM_OFF: assert property (s_pfm_off ##3 1'b1 |-> !pfm_en) else $error("pulse skip not disabled");
  AST_STAT_OFF: assert property (s_stat_off ##3 1'b1 |-> stat_oe_n) else $error("status pin not off");
endmodule

bind cpm_ctrl cpm_ctrl_properties #(.INT_PULSE_CYC(INT_PULSE_CYC)) u_props (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vac_present(vac_present), .sys_above_2v2(sys_above_2v2),
  .internal_gate_supply_en(internal_gate_supply_en), .high_impedance_state(high_impedance_state), .badsrc_en(badsrc_en), .conv_en(conv_en), .batsw_on(batsw_on),
  .pfm_en(pfm_en), .iin_limit(iin_limit), .vin_limit_mv(vin_limit_mv), .int_n(int_n), .stat_oe_n(stat_oe_n)
);

`default_nettype wire

// [test/cpm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cpm_host_model (
  // Clock
  input wire logic clk,
  // Register port toward the controller
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Kicks and forced detection are plain writes; address and data are scrambled once released.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    q = reg_rdata;
  endtask
endmodule

`default_nettype wire

// [test/cpm_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cpm_map.svh"

module cpm_ctrl_bench;
  import cpm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [13:0] ain = 14'h1000;
  logic [12:0] vbat_mv = 13'h0;
  logic [12:0] v;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, p, b;
  logic internal_gate_supply_en, high_impedance_state, badsrc_en, conv_en, batsw_on, pfm_en, int_n, stat_oe_n, rechg_sel, stat_out;
  logic [4:0] iin_limit;
  logic [12:0] vin_limit_mv;
  logic [31:0] seed = 32'h00012fe3;
  logic [31:0] r;
  int n_fail = 0;
  int check_count = 0;
  int i, k, e;

  always #20 clk = ~clk;

  cpm_ctrl #(.INTERNAL_GATE_SUPPLY_DLY_CYC(20), .QUAL_RETRY_CYC(30), .INT_PULSE_CYC(8), .WDT_BASE_CYC(200),
    .SAFETY_CYC(500), .BLINK_HALF_CYC(10)) uut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vac_present(ain[0]), .vac_above_sleep(ain[1]),
    .vac_below_ov(ain[2]), .vbus_above_min(ain[3]), .sys_above_2v2(ain[4]), .bat_above_sysmin(ain[5]),
    .bat_above_low(ain[6]), .light_load(ain[7]), .fast_charge_current_below_term(ain[8]), .vbat_above_rechg(ain[9]),
    .in_dpm(ain[10]), .in_treg(ain[11]), .ce_n(ain[12]), .psel(ain[13]), .vbat_mv(vbat_mv),
    .internal_gate_supply_en(internal_gate_supply_en), .high_impedance_state(high_impedance_state), .badsrc_en(badsrc_en), .conv_en(conv_en), .batsw_on(batsw_on),
    .pfm_en(pfm_en), .rechg_sel(rechg_sel), .iin_limit(iin_limit), .vin_limit_mv(vin_limit_mv), .int_n(int_n),
    .stat_out(stat_out), .stat_oe_n(stat_oe_n)
  );

  cpm_host_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [4:0] lim(input logic s);
    return s ? `CPM_IIN_500MA : `CPM_IIN_2A4;
  endfunction

  function automatic logic [2:0] src(input logic s);
    return s ? `CPM_SRC_USB : `CPM_SRC_ADAPTER;
  endfunction

  function automatic logic [12:0] vtrk(input logic [12:0] b);
    return (b + `CPM_TRACK_1 > `CPM_RST_VIN) ? b + `CPM_TRACK_1 : `CPM_RST_VIN;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #160000;
    n_fail++;
    give_verdict();
  end

  initial begin
    r = xs();
    p = r[0];
    ain[13] = p;
    cyc(8);
    chk("hiz_reset", high_impedance_state, 16'h1);
    chk("alert_reset", int_n, 16'h1);
    nrst <= 1'b1;
    host.rd(4'h5, q);
    chk("timeout_flag", q[7], 16'h1);
    host.rd(4'h1, q);
    chk("vlim_default", q, 16'h1194);
    host.rd(4'h0, q);
    chk("inlim_pin", q[4:0], lim(p));
    host.rd(4'hf, q);
    chk("unmapped", q, 16'h0);
    $display("reset test done");
    @(posedge clk) ain[4:0] <= 5'h17;
    cyc(12);
    chk("supply_early", internal_gate_supply_en, 16'h0);
    for (i = 0; i < 40 && !internal_gate_supply_en; i++) @(posedge clk);
    chk("supply_on", internal_gate_supply_en, 16'h1);
    k = 0;
    for (i = 0; i < 90; i++) begin
      @(posedge clk);
      k += badsrc_en;
    end
    chk("qual_retry", 16'(k >= 2), 16'h1);
    chk("no_start", conv_en, 16'h0);
    @(posedge clk) ain[3] <= 1'b1;
    for (i = 0; i < 100 && !conv_en; i++) @(posedge clk);
    chk("converter", conv_en, 16'h1);
    chk("alert_pulse", int_n, 16'h0);
    host.rd(4'h5, q);
    chk("source_flags", q[4:0], {src(p), 2'h3});
    chk("iin_pin", iin_limit, lim(p));
    @(posedge clk) ain[13] <= ~p;
    cyc(6);
    chk("iin_follow", iin_limit, lim(~p));
    @(posedge clk) ain[4] <= 1'b0;
    cyc(6);
    chk("iin_rail", iin_limit, `CPM_IIN_200MA);
    @(posedge clk) ain[4] <= 1'b1;
    for (e = 0; e < 2; e++) begin
      r = xs();
      v = (e == 0) ? 13'h10cc : 13'h0bb8 + 13'(r % 32'h708);
      @(posedge clk) vbat_mv <= v;
      host.wr(4'h0, 16'h0020);
      cyc(4);
      chk("vlim_track", vin_limit_mv, vtrk(v));
    end
    $display("power-up test done");
    @(posedge clk) ain[12] <= 1'b0;
    ain[6] <= 1'b1;
    ain[5] <= 1'b1;
    cyc(6);
    host.rd(4'h5, q);
    chk("phase_fast", q[6:5], `CPM_PH_FAST);
    chk("stat_charging", stat_oe_n, 16'h0);
    for (e = 0; e < 2; e++) begin
      @(posedge clk) ain[11:8] <= (e == 0) ? 4'h7 : 4'hb;
      cyc(6);
      host.rd(4'h5, q);
      chk("phase_regul", q[6:5], `CPM_PH_FAST);
    end
    @(posedge clk) ain[11:8] <= 4'h3;
    cyc(6);
    host.rd(4'h5, q);
    chk("phase_done", q[6:5], `CPM_PH_DONE);
    chk("stat_done", stat_oe_n, 16'h1);
    @(posedge clk) ain[9] <= 1'b0;
    cyc(6);
    host.rd(4'h5, q);
    chk("phase_rechg", q[6:5], `CPM_PH_FAST);
    @(posedge clk) ain[8] <= 1'b0;
    host.wr(4'h2, 16'h0040);
    cyc(4);
    chk("switch_off", batsw_on, 16'h0);
    host.rd(4'h5, q);
    chk("phase_off", q[6:5], `CPM_PH_OFF);
    @(posedge clk) ain[6] <= 1'b0;
    host.wr(4'h2, 16'h0041);
    cyc(6);
    host.rd(4'h5, q);
    chk("phase_pre", q[6:5], `CPM_PH_PRE);
    chk("pfm_idle", pfm_en, 16'h0);
    @(posedge clk) ain[7] <= 1'b1;
    cyc(6);
    chk("pfm_on", pfm_en, 16'h1);
    host.wr(4'h2, 16'h0047);
    cyc(4);
    chk("pfm_off", pfm_en, 16'h0);
    chk("rechg_sel", rechg_sel, 16'h1);
    host.wr(4'h2, 16'h0059);
    cyc(4);
    chk("stat_off", stat_oe_n, 16'h1);
    $display("charge test done");
    host.wr(4'h4, 16'h001b);
    host.rd(4'h5, q);
    chk("host_mode", q[7], 16'h0);
    @(posedge clk) ain[13] <= p;
    cyc(6);
    chk("iin_held", iin_limit, lim(~p));
    host.wr(4'h2, 16'h0061);
    cyc(4);
    chk("iin_forced", iin_limit, lim(p));
    host.wr(4'h1, 16'h125c);
    cyc(230);
    host.rd(4'h5, q);
    chk("expired", q[7], 16'h1);
    host.rd(4'h2, q);
    chk("chgctl_reset", q, 16'h0041);
    host.rd(4'h1, q);
    chk("vlim_kept", q, 16'h125c);
    host.rd(4'h4, q);
    chk("wdctl_kept", q, 16'h001a);
    $display("watchdog test done");
    cyc(560);
    host.rd(4'h5, q);
    chk("safety_fault", q[8], 16'h1);
    chk("still_running", conv_en, 16'h1);
    chk("stat_out", stat_out, 16'h0);
    k = 0;
    b = stat_oe_n;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      k += (stat_oe_n != b);
      b = stat_oe_n;
    end
    chk("stat_blink", 16'(k >= 3), 16'h1);
    @(posedge clk) ain[0] <= 1'b0;
    cyc(6);
    chk("hiz_drop", high_impedance_state, 16'h1);
    chk("conv_drop", conv_en, 16'h0);
    host.rd(4'h5, q);
    chk("flags_drop", q[1:0], 16'h0);
    $display("safety test done");
    give_verdict();
  end
endmodule

`default_nettype wire
